// ---- rtl/iha_bus_if.sv ----
// Host bus between the processor side and the adapter's register port.
`timescale 1ns/1ns
interface iha_bus_if;
  logic       e;
  logic       cs_b;
  logic       reg_select_bit0;
  logic       reg_select_bit1;
  logic       reg_select_bit2;
  logic       rw;
  logic       dma_grant;
  logic       dma_request;
  logic [7:0] host_wdata;
  logic       host_data_oe_b;
  logic [7:0] dev_rdata;
  logic       dev_data_oe_b;
  logic [7:0] host_data_bus;

  // Wire level of the shared data bus; an undriven bus floats high.
  assign host_data_bus = !dev_data_oe_b  ? dev_rdata  :
                         !host_data_oe_b ? host_wdata : 8'hFF;

  modport dev (
    input  e, cs_b, reg_select_bit0, reg_select_bit1, reg_select_bit2,
    input  rw, dma_grant, host_data_bus,
    output dev_rdata, dev_data_oe_b, dma_request
  );
  modport host (
    output e, cs_b, reg_select_bit0, reg_select_bit1, reg_select_bit2,
    output rw, dma_grant, host_wdata, host_data_oe_b,
    input  host_data_bus, dma_request
  );
endinterface

// ---- rtl/iha_dev_end.sv ----
// Adapter end: register port, address recognition and byte handshakes.
//
// Notes on behaviour
// [R1] Data drivers off except reads and DMA.
// [R2] Host drives active-low select from decoding.
// [R3] Write, no grant: select picks write register.
// [R4] Read, no grant: select picks read register.
// [R5] Hold source byte two microseconds before valid.
// [R6] Shorter settling for three-state driver cases.
// [R7] Clear or remote false idles talk/listen quickly; here remote false only clears remote_o.
// [R8] Three-wire handshake steps strictly in order. The acceptor drops ready and raises accepted in the same cycle.
// [R9] Become active only on own address.
// [R10] Host loads bus address during initialisation.
// [R11] Accept own and multi-device commands under attention.
// [R12] Lower-case limits max, upper-case minimum dwell.
// [R13] Attention change flips transceiver control within 200ns.
// [R14] Grant selects data register, inverts direction.
// [R15] Enable clock qualifies accesses, steps state machines.
// [R16] Sample selects, latch writes in high phase.
`timescale 1ns/1ns
module iha_dev_end (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  iha_bus_if.dev                    hb,
  input  wire iha_pkg::iha_settle_e settle_mode_i,
  input  wire logic [7:0]           addr_switch_i,
  input  wire logic [7:0]           dio_i,
  input  wire logic                 atn_i,
  input  wire logic                 ifc_i,
  input  wire logic                 ren_i,
  input  wire logic                 dav_i,
  input  wire logic                 rfd_i,
  input  wire logic                 dac_i,
  output logic [7:0]                dio_o,
  output logic                      dio_oe_b_o,
  output logic                      dav_o,
  output logic                      rfd_o,
  output logic                      dac_o,
  output logic                      xcvr_direction_ctrl_o,
  output logic                      remote_o,
  output logic                      cmd_stb_o,
  output logic [7:0]                cmd_byte_o
);
  import iha_pkg::*;

  localparam int SYNC_W = 22;

  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_VALID} iha_src_e;
  typedef enum logic {ACC_READY, ACC_WAIT_END} iha_acc_e;

  logic [SYNC_W-1:0]   sync1_q;
  logic [SYNC_W-1:0]   sync2_q;
  logic                atn_s, ifc_s, ren_s, dav_s, rfd_s, dac_s;
  logic [7:0]          dio_s, sw_s;
  logic                e_q, e_rise, e_fall;
  logic                acc_sel_q, acc_rd_q;
  logic [2:0]          acc_idx_q;
  logic [7:0]          wreg_q [NUM_REGS];
  logic                swrst, wr_stb, rd_din;
  logic                bi_q, bo_q, nba_q, first_q;
  logic                talk_q, listen_q;
  logic                part, acc_take, msg_take, src_done;
  logic [7:0]          last_cmd_q, din_q, rdata;
  logic [SETTLE_W-1:0] settle_q, settle_tgt;
  iha_src_e            src_q;
  iha_acc_e            acc_q;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {sw_pins(addr_switch_i, dio_i),
                  atn_i, ifc_i, ren_i, dav_i, rfd_i, dac_i};
      sync2_q <= sync1_q;
    end
  end

  function automatic logic [15:0] sw_pins(logic [7:0] a, logic [7:0] d);
    return {a, d};
  endfunction

  assign {sw_s, dio_s, atn_s, ifc_s, ren_s, dav_s, rfd_s, dac_s} = sync2_q;

  // ==========================================================================
  // Host register port
  // ==========================================================================
  assign e_rise = hb.e && !e_q;
  assign e_fall = !hb.e && e_q;
  assign swrst  = wreg_q[WR_AUX_CMD][AUX_SWRST_BIT];
  // Writes land at the end of the high phase. [R16]
  assign wr_stb = e_fall && acc_sel_q && !acc_rd_q;
  assign rd_din = e_fall && acc_sel_q && acc_rd_q
                  && (acc_idx_q == RD_DATA_IN);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      e_q       <= 1'b0;
      acc_sel_q <= 1'b0;
      acc_rd_q  <= 1'b0;
      acc_idx_q <= RD_INT_STATUS;
    end else begin
      e_q <= hb.e;
      if (e_rise) begin
        // Selects are taken only as E rises; the clock qualifies them. [R15]
        acc_sel_q <= hb.dma_grant || !hb.cs_b;
        if (hb.dma_grant) begin
          acc_idx_q <= REG_DATA; // [R14]
          acc_rd_q  <= !hb.rw; // [R14]
        end else begin
          // Direction and select lines pick the register. [R3] [R4]
          acc_idx_q <= {hb.reg_select_bit2, hb.reg_select_bit1,
                        hb.reg_select_bit0};
          acc_rd_q  <= hb.rw;
        end
      end else if (e_fall) begin
        acc_sel_q <= 1'b0;
      end
    end
  end

  // Slot one has no write register; until software reset is released only
  // the address and auxiliary registers take writes.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        wreg_q[i] <= REG_RESET;
      end
      wreg_q[WR_AUX_CMD] <= AUX_RESET;
    end else if (wr_stb && acc_idx_q != WR_UNUSED) begin // [R3]
      if (!swrst || acc_idx_q == WR_ADDR || acc_idx_q == WR_AUX_CMD) begin
        wreg_q[acc_idx_q] <= hb.host_data_bus;
      end
    end
  end

  always_comb begin
    case (acc_idx_q)
      RD_INT_STATUS:  rdata = {6'h00, bo_q, bi_q};
      RD_CMD_STATUS:  rdata = last_cmd_q;
      RD_ADDR_STATUS: rdata = {5'h00, remote_o, talk_q, listen_q};
      RD_AUX_CMD:     rdata = wreg_q[WR_AUX_CMD];
      RD_ADDR_SWITCH: rdata = sw_s;
      RD_SERIAL_POLL: rdata = wreg_q[WR_SERIAL_POLL];
      RD_PASS_THRU:   rdata = last_cmd_q;
      RD_DATA_IN:     rdata = din_q;
      default:        rdata = REG_RESET;
    endcase
  end

  // Drivers are on for a read access from two cycles after E rises until one cycle after it falls.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hb.dev_rdata     <= REG_RESET;
      hb.dev_data_oe_b <= 1'b1;
      hb.dma_request   <= 1'b0;
    end else begin
      hb.dev_rdata     <= rdata; // [R4]
      hb.dev_data_oe_b <= !(acc_sel_q && acc_rd_q && hb.e && !e_fall); // [R1]
      hb.dma_request   <= (bi_q || bo_q) && !hb.dma_grant;
    end
  end

  // ==========================================================================
  // Transfer flags: a hardware set wins over a clear in the same cycle
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bi_q  <= 1'b0;
      bo_q  <= 1'b0;
      nba_q <= 1'b0;
      din_q <= REG_RESET;
    end else begin
      if (rd_din) bi_q <= 1'b0;
      if (acc_take) begin
        bi_q  <= 1'b1;
        din_q <= dio_s;
      end
      if (wr_stb && acc_idx_q == WR_DATA_OUT && !swrst) begin
        nba_q <= 1'b1;
        bo_q  <= 1'b0;
      end
      if (src_done) begin
        nba_q <= 1'b0;
        bo_q  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Talker, listener and remote state
  // ==========================================================================
  // An interface clear idles both functions within three cycles, well
  // inside the allowed response; a received byte and its flag survive it.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      talk_q     <= 1'b0;
      listen_q   <= 1'b0;
      remote_o   <= 1'b0;
      last_cmd_q <= REG_RESET;
      cmd_stb_o  <= 1'b0;
      cmd_byte_o <= REG_RESET;
    end else begin
      cmd_stb_o <= 1'b0;
      if (ifc_s || swrst) begin
        talk_q   <= 1'b0; // [R7]
        listen_q <= 1'b0; // [R7]
      end else if (msg_take) begin
        last_cmd_q <= dio_s;
        if (dio_s[6:5] == GRP_LISTEN) begin
          if (dio_s[4:0] == ADDR_UNIVERSAL) begin
            listen_q <= 1'b0;
          end else if (dio_s[4:0] == wreg_q[WR_ADDR][4:0]) begin
            listen_q <= 1'b1; // [R9]
          end
        end else if (dio_s[6:5] == GRP_TALK) begin
          talk_q <= dio_s[4:0] == wreg_q[WR_ADDR][4:0]; // [R9]
        end else if (dio_s[6:4] == CMD_UNIVERSAL
                     || (dio_s[6:4] == CMD_ADDRESSED && listen_q)) begin
          cmd_stb_o  <= 1'b1; // [R11]
          cmd_byte_o <= dio_s;
        end
      end
      if (!ren_s || swrst) remote_o <= 1'b0; // [R7]
      else if (listen_q) remote_o <= 1'b1;
    end
  end

  // Attention is watched every system cycle, not on E, so the transceivers
  // turn round three cycles after the pin moves.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) xcvr_direction_ctrl_o <= 1'b0;
    else xcvr_direction_ctrl_o <= talk_q && !atn_s; // [R13]
  end

  // ==========================================================================
  // Acceptor handshake
  // ==========================================================================
  assign part     = atn_s || listen_q;
  assign acc_take = e_rise && acc_q == ACC_READY && part && rfd_o && dav_s
                    && !atn_s;
  assign msg_take = e_rise && acc_q == ACC_READY && rfd_o && dav_s && atn_s;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_q <= ACC_READY;
      rfd_o <= 1'b1;
      dac_o <= 1'b1;
    end else if (e_rise) begin // [R15]
      case (acc_q)
        ACC_READY: begin
          if (acc_take || msg_take) begin
            // Not ready and accepted both change on this same E rise. [R8]
            rfd_o <= 1'b0;
            dac_o <= 1'b1;
            acc_q <= ACC_WAIT_END;
          end else begin
            rfd_o <= part ? (atn_s || !bi_q) : 1'b1;
            dac_o <= !part;
          end
        end
        ACC_WAIT_END: begin
          if (!dav_s) begin
            dac_o <= !part; // [R8]
            acc_q <= ACC_READY;
          end
        end
        default: acc_q <= ACC_READY;
      endcase
    end
  end

  // ==========================================================================
  // Source handshake
  // ==========================================================================
  // The settle count is a least dwell, so valid is never raised before it
  // expires; the step to valid lags by up to one E period, longer while ready is low. [R12]
  always_comb begin
    case (settle_mode_i)
      SETTLE_3S:    settle_tgt = first_q ? T1_3S_CYC : T1_NEXT_CYC; // [R6]
      SETTLE_ATN3S: settle_tgt = first_q ? T1_ATN3S_CYC : T1_NEXT_CYC; // [R6]
      default:      settle_tgt = T1_CYC; // [R5]
    endcase
  end

  assign src_done = e_rise && src_q == SRC_VALID && dac_s
                    && talk_q && !atn_s;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_q      <= SRC_IDLE;
      settle_q   <= SETTLE_ZERO;
      first_q    <= 1'b1;
      dav_o      <= 1'b0;
      dio_o      <= BUS_IDLE;
      dio_oe_b_o <= 1'b1;
    end else begin
      if (settle_q != SETTLE_ZERO) settle_q <= settle_q - SETTLE_ONE;
      if (atn_s) first_q <= 1'b1;
      if (!talk_q || atn_s) begin
        src_q      <= SRC_IDLE;
        dav_o      <= 1'b0;
        dio_oe_b_o <= 1'b1;
      end else if (e_rise) begin // [R15]
        case (src_q)
          SRC_IDLE: begin
            if (nba_q) begin
              dio_o      <= wreg_q[WR_DATA_OUT];
              dio_oe_b_o <= 1'b0;
              settle_q   <= settle_tgt; // [R5]
              src_q      <= SRC_SETTLE;
            end
          end
          SRC_SETTLE: begin
            if (settle_q == SETTLE_ZERO && rfd_s) begin
              dav_o <= 1'b1; // [R8]
              src_q <= SRC_VALID;
            end
          end
          SRC_VALID: begin
            if (dac_s) begin
              dav_o      <= 1'b0; // [R8]
              dio_oe_b_o <= 1'b1;
              first_q    <= 1'b0;
              src_q      <= SRC_IDLE;
            end
          end
          default: src_q <= SRC_IDLE;
        endcase
      end
    end
  end

endmodule

// ---- rtl/iha_host_end.sv ----
// Processor-side end: makes the enable clock and runs register accesses.
`timescale 1ns/1ns
module iha_host_end (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  iha_bus_if.host         hb,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic       cmd_dma_i,
  input  wire logic [2:0] cmd_index_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_rdata_o
);
  import iha_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_WAIT_LOW, H_WAIT_HIGH, H_HIGH, H_HOLD
  } iha_host_st_e;

  iha_host_st_e   st_q;
  logic [E_W-1:0] ecnt_q;
  logic           e_tick;
  logic           wr_q;
  logic           dma_q;
  logic [2:0]     idx_q;
  logic [7:0]     wdata_q;

  // ==========================================================================
  // Free-running enable clock
  // ==========================================================================
  assign e_tick = (ecnt_q == E_CNT_ONE);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ecnt_q <= E_HALF_CYC;
      hb.e   <= 1'b0;
    end else if (e_tick) begin
      ecnt_q <= E_HALF_CYC;
      hb.e   <= !hb.e;
    end else begin
      ecnt_q <= ecnt_q - E_CNT_ONE;
    end
  end

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  // Select and direction are set up a whole low phase before E rises, data as
  // E rises; all are held one cycle past its fall, so the adapter sees them stable.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q               <= H_IDLE;
      cmd_ready_o        <= 1'b1;
      rsp_valid_o        <= 1'b0;
      rsp_rdata_o        <= REG_RESET;
      wr_q               <= 1'b0;
      dma_q              <= 1'b0;
      idx_q              <= RD_INT_STATUS;
      wdata_q            <= REG_RESET;
      hb.cs_b            <= 1'b1;
      hb.reg_select_bit0 <= 1'b0;
      hb.reg_select_bit1 <= 1'b0;
      hb.reg_select_bit2 <= 1'b0;
      hb.rw              <= 1'b1;
      hb.dma_grant       <= 1'b0;
      hb.host_wdata      <= REG_RESET;
      hb.host_data_oe_b  <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd_valid_i) begin
            wr_q        <= cmd_write_i;
            dma_q       <= cmd_dma_i;
            idx_q       <= cmd_index_i;
            wdata_q     <= cmd_wdata_i;
            cmd_ready_o <= 1'b0;
            st_q        <= H_WAIT_LOW;
          end
        end
        H_WAIT_LOW: begin
          if (e_tick && hb.e) begin
            // The select is driven low for every access made without grant, from the command's DMA flag. [R2]
            hb.cs_b            <= dma_q;
            hb.dma_grant       <= dma_q;
            hb.reg_select_bit0 <= idx_q[0];
            hb.reg_select_bit1 <= idx_q[1];
            hb.reg_select_bit2 <= idx_q[2];
            // Under grant a memory write reads the adapter. [R14]
            hb.rw              <= dma_q ? wr_q : !wr_q;
            st_q               <= H_WAIT_HIGH;
          end
        end
        H_WAIT_HIGH: begin
          if (e_tick) begin
            // Address loading at start-up is an ordinary write. [R10]
            hb.host_wdata     <= wdata_q;
            hb.host_data_oe_b <= !wr_q;
            st_q              <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (e_tick) begin
            st_q <= H_HOLD;
          end
        end
        H_HOLD: begin
          rsp_rdata_o       <= hb.host_data_bus;
          rsp_valid_o       <= 1'b1;
          cmd_ready_o       <= 1'b1;
          hb.cs_b           <= 1'b1;
          hb.dma_grant      <= 1'b0;
          hb.rw             <= 1'b1;
          hb.host_data_oe_b <= 1'b1;
          st_q              <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/iha_pkg.sv ----
// Shared constants and types for the IEEE-488 adapter host port.
package iha_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SETTLE_W       = 6;
  // Least times round up to whole clock cycles.
  localparam int T1_NS          = 2000;
  localparam int T1_3S_NS       = 1100;
  localparam int T1_ATN3S_NS    = 700;
  localparam int T1_NEXT_NS     = 500;
  localparam logic [SETTLE_W-1:0] T1_CYC =
    SETTLE_W'((T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SETTLE_W-1:0] T1_3S_CYC =
    SETTLE_W'((T1_3S_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SETTLE_W-1:0] T1_ATN3S_CYC =
    SETTLE_W'((T1_ATN3S_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SETTLE_W-1:0] T1_NEXT_CYC =
    SETTLE_W'((T1_NEXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 6'h00;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE  = 6'h01;

  // Bus enable clock: each half period lasts this many system cycles.
  localparam int E_W = 4;
  localparam logic [E_W-1:0] E_HALF_CYC = 4'hA;
  localparam logic [E_W-1:0] E_CNT_ONE  = 4'h1;
  localparam logic [E_W-1:0] E_CNT_ZERO = 4'h0;

  // ==========================================================================
  // Register map (index on the three select lines)
  // ==========================================================================
  localparam logic [2:0] RD_INT_STATUS  = 3'h0;
  localparam logic [2:0] RD_CMD_STATUS  = 3'h1;
  localparam logic [2:0] RD_ADDR_STATUS = 3'h2;
  localparam logic [2:0] RD_AUX_CMD     = 3'h3;
  localparam logic [2:0] RD_ADDR_SWITCH = 3'h4;
  localparam logic [2:0] RD_SERIAL_POLL = 3'h5;
  localparam logic [2:0] RD_PASS_THRU   = 3'h6;
  localparam logic [2:0] RD_DATA_IN     = 3'h7;
  localparam logic [2:0] WR_INT_MASK    = 3'h0;
  localparam logic [2:0] WR_UNUSED      = 3'h1;
  localparam logic [2:0] WR_ADDR_MODE   = 3'h2;
  localparam logic [2:0] WR_AUX_CMD     = 3'h3;
  localparam logic [2:0] WR_ADDR        = 3'h4;
  localparam logic [2:0] WR_SERIAL_POLL = 3'h5;
  localparam logic [2:0] WR_PAR_POLL    = 3'h6;
  localparam logic [2:0] WR_DATA_OUT    = 3'h7;
  localparam logic [2:0] REG_DATA       = 3'h7;
  localparam int         NUM_REGS       = 8;

  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] AUX_RESET      = 8'h80;
  localparam int         AUX_SWRST_BIT  = 7;
  localparam logic [7:0] BUS_IDLE       = 8'hFF;

  // ==========================================================================
  // Bus messages received under attention
  // ==========================================================================
  localparam logic [1:0] GRP_LISTEN     = 2'h1;
  localparam logic [1:0] GRP_TALK       = 2'h2;
  localparam logic [4:0] ADDR_UNIVERSAL = 5'h1F;
  localparam logic [2:0] CMD_ADDRESSED  = 3'h0;
  localparam logic [2:0] CMD_UNIVERSAL  = 3'h1;

  typedef enum logic [1:0] {
    SETTLE_OPEN,
    SETTLE_3S,
    SETTLE_ATN3S
  } iha_settle_e;

endpackage

// ---- tb/ieee488_adapter_host_port_bench.sv ----
// Bench joining both ends, with a controller and acceptor around them.
`timescale 1ns/1ns
module ieee488_adapter_host_port_bench;
  import iha_pkg::*;
  logic        clk_sys_i, rst_b_i, cmd_valid_i, cmd_write_i, cmd_dma_i;
  logic [2:0]  cmd_index_i;
  logic [7:0]  cmd_wdata_i, rsp_rdata_o, addr_switch_i, dio_i, dio_o;
  logic [7:0]  cmd_byte_o, rd, b;
  logic        cmd_ready_o, rsp_valid_o, atn_i, ifc_i, ren_i, dav_i, rfd_i;
  logic        dac_i, dio_oe_b_o, dav_o, rfd_o, dac_o, remote_o, cmd_stb_o;
  logic        xcvr_direction_ctrl_o;
  logic [4:0]  me;
  iha_settle_e settle_mode_i;
  int          fails = 0, num_checks = 0, seed;
  logic [7:0]  cmd_q[$], data_q[$];
  iha_bus_if   bus ();
  iha_host_end i_iha_host_end (.clk_sys_i, .rst_b_i, .hb(bus), .cmd_valid_i,
    .cmd_write_i, .cmd_dma_i, .cmd_index_i, .cmd_wdata_i, .cmd_ready_o,
    .rsp_valid_o, .rsp_rdata_o);
  iha_dev_end i_iha_dev_end (.clk_sys_i, .rst_b_i, .hb(bus), .settle_mode_i,
    .addr_switch_i, .dio_i, .atn_i, .ifc_i, .ren_i, .dav_i, .rfd_i, .dac_i,
    .dio_o, .dio_oe_b_o, .dav_o, .rfd_o, .dac_o, .xcvr_direction_ctrl_o,
    .remote_o, .cmd_stb_o, .cmd_byte_o);
  iha_assertions i_iha_assertions (.clk_sys_i, .rst_b_i, .cs_b(bus.cs_b),
    .rw(bus.rw), .dma_grant(bus.dma_grant), .dma_request(bus.dma_request),
    .dev_data_oe_b(bus.dev_data_oe_b), .settle_mode_i, .atn_i, .dac_i,
    .dio_o, .dio_oe_b_o, .dav_o, .rfd_o, .dac_o, .xcvr_direction_ctrl_o,
    .cmd_stb_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // The run needs well under five thousand cycles; this allows more than ten times that.
  initial begin
    #2500000;
    fails++;
    end_sim();
  end
  always @(negedge clk_sys_i) begin
    if (cmd_stb_o === 1'b1) cmd_q.push_back(cmd_byte_o);
  end
  // ==========================================================
  // Tasks
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(ref logic s, input logic lv);
    for (int k = 0; k < 400 && s !== lv; k++) @(negedge clk_sys_i);
    chk({7'h00, s}, {7'h00, lv});
  endtask
  task automatic hop(input logic d, w, input logic [2:0] x,
                     input logic [7:0] v);
    repeat (2) @(negedge clk_sys_i);
    {cmd_dma_i, cmd_write_i, cmd_index_i, cmd_wdata_i} = {d, w, x, v};
    cmd_valid_i = 1'b1;
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    chk({7'h00, cmd_ready_o}, 8'h00);
    wt(rsp_valid_o, 1'b1);
    rd = rsp_rdata_o;
  endtask
  // The released data lines show the inverse, never the last byte.
  task automatic src(input logic [7:0] v);
    wt(rfd_o, 1'b1);
    wt(dac_o, 1'b0);
    dio_i = v;
    repeat (45) @(negedge clk_sys_i);
    dav_i = 1'b1;
    wt(rfd_o, 1'b0);
    wt(dac_o, 1'b1);
    dav_i = 1'b0;
    dio_i = ~v;
    wt(dac_o, 1'b0);
  endtask
  task automatic acc(input logic [7:0] v);
    wt(dav_o, 1'b1);
    chk(dio_o, v);
    rfd_i = 1'b0;
    dac_i = 1'b1;
    wt(dav_o, 1'b0);
    dac_i = 1'b0;
    rfd_i = 1'b1;
  endtask
  task automatic status(input logic [7:0] exp);
    hop(0, 0, RD_ADDR_STATUS, 8'h00);
    chk(rd, exp);
  endtask
  initial begin
    seed = 32'h6E55;
    {cmd_valid_i, cmd_write_i, cmd_dma_i, cmd_index_i} = 6'h00;
    {atn_i, ifc_i, ren_i, dav_i, dac_i, rfd_i} = 6'h01;
    cmd_wdata_i = 8'h00;
    dio_i = 8'hFF;
    addr_switch_i = 8'($random(seed));
    me = 5'h02 + 5'($unsigned($random(seed)) % 28);
    settle_mode_i = SETTLE_OPEN;
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    hop(0, 1, WR_ADDR, {3'h0, me});
    hop(0, 0, RD_ADDR_SWITCH, 8'h00);
    chk(rd, addr_switch_i);
    hop(0, 1, WR_AUX_CMD, 8'h00);
    hop(0, 0, RD_AUX_CMD, 8'h00);
    chk(rd, 8'h00);
    atn_i = 1'b1;
    src({3'h1, me});
    status(8'h01);
    for (int i = 0; i < 2; i++) begin
      b = i[0] ? 8'h04 : 8'h14;
      src(b);
      chk(cmd_q.pop_front(), b);
    end
    atn_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      data_q.push_back(b);
      src(b);
      chk({7'h00, bus.dma_request}, 8'h01);
      hop(i[0], 0, RD_DATA_IN, 8'h00);
      chk(rd, data_q.pop_front());
    end
    ren_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    status(8'h05);
    ren_i = 1'b0;
    repeat (40) @(negedge clk_sys_i);
    chk({7'h00, remote_o}, 8'h00);
    atn_i = 1'b1;
    src(8'h3F);
    src({3'h2, me});
    status(8'h02);
    atn_i = 1'b0;
    for (int m = 0; m < 6; m++) begin
      settle_mode_i = iha_settle_e'(m / 2);
      b = 8'($random(seed));
      hop(m[0], 1, WR_DATA_OUT, b);
      acc(b);
      hop(0, 0, RD_INT_STATUS, 8'h00);
      chk(rd, 8'h02);
    end
    atn_i = 1'b1;
    src({3'h2, me + 5'h01});
    status(8'h00);
    src({3'h1, me});
    status(8'h01);
    ifc_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    ifc_i = 1'b0;
    status(8'h00);
    end_sim();
  end
endmodule

// ---- tb/iha_assertions.sv ----
// Checker on the host bus and link pins of the joined adapter ends.
`timescale 1ns/1ns
module iha_assertions (
  input wire logic                 clk_sys_i,
  input wire logic                 rst_b_i,
  input wire logic                 cs_b,
  input wire logic                 rw,
  input wire logic                 dma_grant,
  input wire logic                 dma_request,
  input wire logic                 dev_data_oe_b,
  input wire iha_pkg::iha_settle_e settle_mode_i,
  input wire logic                 atn_i,
  input wire logic                 dac_i,
  input wire logic [7:0]           dio_o,
  input wire logic                 dio_oe_b_o,
  input wire logic                 dav_o,
  input wire logic                 rfd_o,
  input wire logic                 dac_o,
  input wire logic                 xcvr_direction_ctrl_o,
  input wire logic                 cmd_stb_o
);
  import iha_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Settling counter
  logic [5:0] held_q;
  // It saturates, so a long stall never wraps into a short count.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) held_q <= 6'h00;
    else if (dio_oe_b_o) held_q <= 6'h00;
    else if (held_q != 6'h3F) held_q <= held_q + 6'h01;
  end
  AST_DRV_READ_ONLY: assert property (
    !dev_data_oe_b |-> (!cs_b || dma_grant) && (rw != dma_grant))
    else $error("device drove data outside a read");
  AST_DMA_REQ_OFF: assert property (
    dma_grant && $past(dma_grant) |-> !dma_request)
    else $error("request still high under grant");
  AST_SETTLE: assert property (
    $rose(dav_o) |-> held_q >= ((settle_mode_i == SETTLE_OPEN) ?
    T1_CYC : T1_NEXT_CYC)) else $error("byte not settled before valid");
  AST_DIO_HOLD: assert property (
    dav_o |-> !dio_oe_b_o && $stable(dio_o))
    else $error("data moved while valid");
  // Link pins pass two flops, so the logic acts on values three samples old.
  AST_DAV_DROP: assert property (
    $fell(dav_o) |-> $past(dac_i, 3) || $past(atn_i, 3))
    else $error("valid dropped early");
  AST_ACCEPT: assert property (
    $fell(rfd_o) |-> dac_o) else $error("ready dropped without accept");
  AST_ATN_RX: assert property (
    $rose(atn_i) |-> ##[1:4] (!xcvr_direction_ctrl_o && dio_oe_b_o))
    else $error("late turn to receive on attention");
  AST_CMD_ATN: assert property (
    cmd_stb_o |-> $past(atn_i, 3))
    else $error("command strobe without attention");
  CV_SOURCE: cover property ($rose(dav_o));
  CV_CMD: cover property (cmd_stb_o);
  CV_DMA_RD: cover property (dma_grant && !dev_data_oe_b);
endmodule
